// >>> src/synth_ctl_pkg.sv
package synth_ctl_pkg;

	// bus register offsets (byte addresses)
	localparam logic [7:0] CTRL_OFFS = 8'h00;
	localparam logic [7:0] CMD_OFFS = 8'h04;
	localparam logic [7:0] STATUS_OFFS = 8'h08;
	localparam logic [7:0] ACC_LO_OFFS = 8'h0c;
	localparam logic [7:0] ACC_HI_OFFS = 8'h10;
	localparam logic [7:0] PHASE_OFFS = 8'h14;

	// control register fields
	localparam int MODE_LSB = 0;
	localparam int UPD_DIR_BIT = 3;
	localparam int OSK_EN_BIT = 4;
	localparam int RATE_LSB = 8;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_ff1f;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0100;

	// operating mode field encodings
	typedef enum logic [2:0] {
		MODE_SINGLE = 3'h0,
		MODE_FSK = 3'h1,
		MODE_RAMP_FSK = 3'h2,
		MODE_CHIRP = 3'h3,
		MODE_BPSK = 3'h4
	} op_mode_e;

	// programming register byte map
	localparam int NUM_PROG_BYTES = 64;
	localparam int PHASE1_BYTE = 0;
	localparam int PHASE2_BYTE = 2;
	localparam int FREQ1_BYTE = 4;
	localparam int FREQ2_BYTE = 10;
	localparam int DELTA_BYTE = 16;
	typedef logic [7:0] prog_t [NUM_PROG_BYTES];

	// serial transfer framing
	localparam logic [4:0] SER_INSTR_LAST = 5'h07;
	localparam logic [4:0] SER_DATA_FIRST = 5'h08;
	localparam logic [4:0] SER_DATA_LAST = 5'h0f;
	localparam int SER_READ_BIT = 7;

	// update strobe output pulse length in system clock cycles
	localparam logic [3:0] UPD_PULSE_CYCLES = 4'h8;

	localparam logic [11:0] AMP_FULL = 12'hfff;
	localparam logic [11:0] AMP_ZERO = 12'h000;
	localparam int SYNC_WIDTH = 20;

endpackage

// >>> src/pin_sync2.sv
`timescale 1ns/1ps
module pin_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk, // system clock
	input wire logic srst, // synchronous reset
	input wire logic [WIDTH-1:0] async_in, // pins from outside the clock domain
	output logic [WIDTH-1:0] sync_out // two-stage synchronised copy
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_d;

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= meta_d;
			sync_out <= sync_d;
		end
	end
endmodule // pin_sync2

// >>> src/osk_ramp.sv
`timescale 1ns/1ps
module osk_ramp (
	input wire logic sys_clk, // system clock
	input wire logic srst, // synchronous reset
	input wire logic enable, // shaped keying enabled
	input wire logic key_high, // synchronised keying pin level
	input wire logic [7:0] rate, // cycles per step minus one
	output logic [11:0] amp_q // cosine amplitude scale
);
	logic [7:0] pre_q;
	logic [7:0] pre_d;
	logic [11:0] amp_d;

	always_comb begin
		pre_d = pre_q;
		amp_d = amp_q;
		if (!enable) begin
			// pin ignored: output stays at full scale
			pre_d = 8'h00;
			amp_d = synth_ctl_pkg::AMP_FULL;
		end else if (pre_q >= rate) begin
			pre_d = 8'h00;
			if (key_high && amp_q != synth_ctl_pkg::AMP_FULL)
				amp_d = amp_q + 12'h001;
			else if (!key_high && amp_q != synth_ctl_pkg::AMP_ZERO)
				amp_d = amp_q - 12'h001;
		end else begin
			pre_d = pre_q + 8'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pre_q <= 8'h00;
			amp_q <= synth_ctl_pkg::AMP_FULL;
		end else begin
			pre_q <= pre_d;
			amp_q <= amp_d;
		end
	end

	property p_ramp_up;
		@(posedge sys_clk) disable iff (srst)
		enable && $past(enable) && key_high |=> amp_q >= $past(amp_q);
	endproperty
	a_ramp_up: assert property (p_ramp_up) else $error("amplitude fell while keying high");

	property p_ramp_down;
		@(posedge sys_clk) disable iff (srst)
		enable && $past(enable) && !key_high |=> amp_q <= $past(amp_q);
	endproperty
	a_ramp_down: assert property (p_ramp_down) else $error("amplitude rose while keying low");
endmodule // osk_ramp

// >>> src/synth_control_pin_interface.sv
`timescale 1ns/1ps
// Behaviour
// - address bit zero, or serial data line
// - update pin direction from control; output after reset
// - input update edge copies buffers to registers
// - output update gives eight-cycle high pulse
// - serial data sampled on serial clock rise
// - write strobe loads buffers; role follows select
// - parallel read strobe returns register contents
// - serial mode: pin is active-low chip select
// - frequency keying: low first, high second word
// - phase keying: low first, high second offset
// - chirp: high holds frequency accumulator
// - chirp: low starts or resumes sweep
// - shaped keying pin ignored unless enabled
// - shaped keying high ramps amplitude up
// - shaped keying low ramps amplitude down
// - select low serial, high parallel
// - serial port reset clears transfer, keeps registers
// - mode field encodings 000 to 100
module synth_control_pin_interface (
	input wire logic sys_clk, // system clock, 100 MHz
	input wire logic srst, // synchronous reset, active high
	input wire logic hsel, // ahb slave select
	input wire logic [31:0] haddr, // ahb address
	input wire logic [1:0] htrans, // ahb transfer type
	input wire logic hwrite, // ahb write
	input wire logic [2:0] hsize, // ahb size, word only
	input wire logic [31:0] hwdata, // ahb write data
	input wire logic hready, // ahb bus ready
	output logic [31:0] hrdata, // ahb read data
	output logic hreadyout, // ahb slave ready
	output logic hresp, // ahb response, always okay
	input wire logic ser_par_select, // low serial, high parallel
	input wire logic [2:0] addr_upper_bits, // address bits 5..3
	input wire logic addr2_serial_port_reset, // address bit 2 or serial reset
	input wire logic addr1_in, // address bit 1
	input wire logic addr0_serial_data_io_in, // address bit 0 or serial data in
	output logic addr0_serial_data_io_out, // serial data out
	output logic addr0_serial_data_io_oe, // serial data drive enable
	input wire logic wr_sclk, // write strobe or serial clock
	input wire logic rd_cs_n, // read strobe or chip select, low active
	input wire logic [7:0] data_bus_in, // parallel data in
	output logic [7:0] data_bus_out, // parallel data out
	output logic data_bus_oe, // parallel data drive enable
	input wire logic register_update_strobe_in, // update clock pin in
	output logic register_update_strobe_out, // update clock pin out
	output logic register_update_strobe_oe, // update clock drive enable
	input wire logic keying_select_hold_pin, // keying select or hold
	input wire logic shaped_keying_pin, // shaped keying level
	output logic [47:0] freq_word_out, // active frequency word
	output logic [13:0] phase_offset_out, // active phase offset
	output logic [11:0] cos_amplitude_out // cosine amplitude scale
);
	logic [19:0] sync_s;
	logic par_s, io_rst_s, sdio_s, wr_s, rd_n_s, upd_s, key_s, osk_s;
	logic [5:0] addr_s;
	logic [7:0] data_s;

	pin_sync2 #(.WIDTH(synth_ctl_pkg::SYNC_WIDTH)) u_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.async_in({ser_par_select, addr_upper_bits, addr2_serial_port_reset, addr1_in,
			addr0_serial_data_io_in, wr_sclk, rd_cs_n, data_bus_in, register_update_strobe_in,
			keying_select_hold_pin, shaped_keying_pin}),
		.sync_out(sync_s)
	);

	always_comb begin
		par_s = sync_s[19];
		addr_s = sync_s[18:13];
		io_rst_s = sync_s[15];
		sdio_s = sync_s[13];
		wr_s = sync_s[12];
		rd_n_s = sync_s[11];
		data_s = sync_s[10:3];
		upd_s = sync_s[2];
		key_s = sync_s[1];
		osk_s = sync_s[0];
	end

	// bus slave state
	logic pend_q, pend_d, wr_q, wr_d, rdy_d, cmd_upd_q, cmd_upd_d;
	logic [7:0] a_q, a_d;
	logic [31:0] rdata_d, ctrl_q, ctrl_d;
	// port state
	synth_ctl_pkg::prog_t buf_q, buf_d, act_q, act_d;
	logic wr_prev_q, wr_prev_d, upd_prev_q, upd_prev_d;
	logic [4:0] bit_cnt_q, bit_cnt_d;
	logic [7:0] shift_q, shift_d, instr_q, instr_d, byte_in;
	logic sdio_out_d, sdio_oe_d, dbus_oe_d;
	logic [7:0] dbus_out_d;
	logic [3:0] upd_cnt_q, upd_cnt_d;
	logic upd_out_d, upd_oe_d, do_update, wr_rise, sclk_fall, dir_in, osk_en;
	// keying datapath
	logic [47:0] acc_q, acc_d, f1, f2, delta, freq_d;
	logic [13:0] p1, p2, phase_d;
	logic hold;
	synth_ctl_pkg::op_mode_e mode;

	function automatic logic [47:0] word48(synth_ctl_pkg::prog_t r, int b);
		word48 = {r[b], r[b+1], r[b+2], r[b+3], r[b+4], r[b+5]};
	endfunction

	always_comb begin
		pend_d = 1'b0;
		wr_d = wr_q;
		a_d = a_q;
		rdy_d = 1'b1;
		rdata_d = hrdata;
		ctrl_d = ctrl_q;
		cmd_upd_d = 1'b0;
		if (pend_q) begin
			// data phase: one wait state so read data leaves a flip-flop
			if (wr_q) begin
				if (a_q == synth_ctl_pkg::CTRL_OFFS)
					ctrl_d = hwdata & synth_ctl_pkg::CTRL_WMASK;
				else if (a_q == synth_ctl_pkg::CMD_OFFS)
					cmd_upd_d = hwdata[0];
			end else begin
				unique case (a_q)
					synth_ctl_pkg::CTRL_OFFS: rdata_d = ctrl_q;
					synth_ctl_pkg::STATUS_OFFS: rdata_d = {16'h0000, cos_amplitude_out, hold,
						register_update_strobe_out, key_s, par_s};
					synth_ctl_pkg::ACC_LO_OFFS: rdata_d = acc_q[31:0];
					synth_ctl_pkg::ACC_HI_OFFS: rdata_d = {16'h0000, acc_q[47:32]};
					synth_ctl_pkg::PHASE_OFFS: rdata_d = {18'h00000, phase_offset_out};
					default: rdata_d = 32'h0000_0000;
				endcase
			end
		end else if (hsel && htrans[1] && hready) begin
			pend_d = 1'b1;
			rdy_d = 1'b0;
			wr_d = hwrite;
			a_d = {haddr[7:2], 2'b00};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pend_q <= 1'b0;
			wr_q <= 1'b0;
			a_q <= 8'h00;
			hreadyout <= 1'b1;
			hrdata <= 32'h0000_0000;
			hresp <= 1'b0;
			ctrl_q <= synth_ctl_pkg::CTRL_RESET;
			cmd_upd_q <= 1'b0;
		end else begin
			pend_q <= pend_d;
			wr_q <= wr_d;
			a_q <= a_d;
			hreadyout <= rdy_d;
			hrdata <= rdata_d;
			hresp <= 1'b0;
			ctrl_q <= ctrl_d;
			cmd_upd_q <= cmd_upd_d;
		end
	end

	always_comb begin
		mode = synth_ctl_pkg::op_mode_e'(ctrl_q[synth_ctl_pkg::MODE_LSB +: 3]);
		dir_in = ctrl_q[synth_ctl_pkg::UPD_DIR_BIT];
		osk_en = ctrl_q[synth_ctl_pkg::OSK_EN_BIT];
		buf_d = buf_q;
		act_d = act_q;
		wr_prev_d = wr_s;
		upd_prev_d = upd_s;
		bit_cnt_d = bit_cnt_q;
		shift_d = shift_q;
		instr_d = instr_q;
		sdio_out_d = addr0_serial_data_io_out;
		sdio_oe_d = addr0_serial_data_io_oe;
		wr_rise = wr_s && !wr_prev_q;
		sclk_fall = !wr_s && wr_prev_q;
		byte_in = {shift_q[6:0], sdio_s};
		// parallel read drives the bus while the strobe is low
		dbus_oe_d = par_s && !rd_n_s;
		dbus_out_d = act_q[addr_s];
		if (par_s) begin
			// parallel: pin 0 is an address bit, never driven
			bit_cnt_d = 5'h00;
			sdio_oe_d = 1'b0;
			if (wr_rise)
				buf_d[addr_s] = data_s;
		end else if (rd_n_s || io_rst_s) begin
			// chip select high or serial reset aborts only the transfer
			bit_cnt_d = 5'h00;
			sdio_oe_d = 1'b0;
		end else begin
			if (wr_rise) begin
				shift_d = byte_in;
				bit_cnt_d = bit_cnt_q + 5'h01;
				if (bit_cnt_q == synth_ctl_pkg::SER_INSTR_LAST) begin
					instr_d = byte_in;
					if (byte_in[synth_ctl_pkg::SER_READ_BIT])
						shift_d = act_q[byte_in[5:0]];
				end else if (bit_cnt_q == synth_ctl_pkg::SER_DATA_LAST) begin
					bit_cnt_d = 5'h00;
					if (!instr_q[synth_ctl_pkg::SER_READ_BIT])
						buf_d[instr_q[5:0]] = byte_in;
				end
			end
			if (sclk_fall) begin
				// read data changes on the falling edge, ahead of the host's sampling rise
				sdio_oe_d = instr_q[synth_ctl_pkg::SER_READ_BIT] && bit_cnt_q >= synth_ctl_pkg::SER_DATA_FIRST;
				sdio_out_d = shift_q[7];
			end
		end
		do_update = dir_in ? (upd_s && !upd_prev_q) : cmd_upd_q;
		if (do_update)
			act_d = buf_q;
		upd_cnt_d = upd_cnt_q;
		if (!dir_in && cmd_upd_q)
			upd_cnt_d = synth_ctl_pkg::UPD_PULSE_CYCLES;
		else if (upd_cnt_q != 4'h0)
			upd_cnt_d = upd_cnt_q - 4'h1;
		upd_out_d = upd_cnt_d != 4'h0 && !dir_in;
		upd_oe_d = !dir_in;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			for (int i = 0; i < synth_ctl_pkg::NUM_PROG_BYTES; i++) begin
				buf_q[i] <= 8'h00;
				act_q[i] <= 8'h00;
			end
			wr_prev_q <= 1'b0;
			upd_prev_q <= 1'b0;
			bit_cnt_q <= 5'h00;
			shift_q <= 8'h00;
			instr_q <= 8'h00;
			addr0_serial_data_io_out <= 1'b0;
			addr0_serial_data_io_oe <= 1'b0;
			data_bus_out <= 8'h00;
			data_bus_oe <= 1'b0;
			upd_cnt_q <= 4'h0;
			register_update_strobe_out <= 1'b0;
			register_update_strobe_oe <= 1'b1;
		end else begin
			buf_q <= buf_d;
			act_q <= act_d;
			wr_prev_q <= wr_prev_d;
			upd_prev_q <= upd_prev_d;
			bit_cnt_q <= bit_cnt_d;
			shift_q <= shift_d;
			instr_q <= instr_d;
			addr0_serial_data_io_out <= sdio_out_d;
			addr0_serial_data_io_oe <= sdio_oe_d;
			data_bus_out <= dbus_out_d;
			data_bus_oe <= dbus_oe_d;
			upd_cnt_q <= upd_cnt_d;
			register_update_strobe_out <= upd_out_d;
			register_update_strobe_oe <= upd_oe_d;
		end
	end

	always_comb begin
		f1 = word48(act_q, synth_ctl_pkg::FREQ1_BYTE);
		f2 = word48(act_q, synth_ctl_pkg::FREQ2_BYTE);
		delta = word48(act_q, synth_ctl_pkg::DELTA_BYTE);
		p1 = {act_q[synth_ctl_pkg::PHASE1_BYTE][5:0], act_q[synth_ctl_pkg::PHASE1_BYTE+1]};
		p2 = {act_q[synth_ctl_pkg::PHASE2_BYTE][5:0], act_q[synth_ctl_pkg::PHASE2_BYTE+1]};
		hold = mode == synth_ctl_pkg::MODE_CHIRP && key_s;
		acc_d = f1;
		freq_d = f1;
		phase_d = p1;
		unique case (mode)
			synth_ctl_pkg::MODE_FSK, synth_ctl_pkg::MODE_RAMP_FSK: freq_d = key_s ? f2 : f1;
			synth_ctl_pkg::MODE_BPSK: phase_d = key_s ? p2 : p1;
			synth_ctl_pkg::MODE_CHIRP: begin
				// accumulator keeps its place over a hold
				acc_d = hold ? acc_q : acc_q + delta;
				freq_d = acc_q;
			end
			default: freq_d = f1;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			acc_q <= 48'h0000_0000_0000;
			freq_word_out <= 48'h0000_0000_0000;
			phase_offset_out <= 14'h0000;
		end else begin
			acc_q <= acc_d;
			freq_word_out <= freq_d;
			phase_offset_out <= phase_d;
		end
	end

	osk_ramp u_ramp (
		.sys_clk(sys_clk),
		.srst(srst),
		.enable(osk_en),
		.key_high(osk_s),
		.rate(ctrl_q[synth_ctl_pkg::RATE_LSB +: 8]),
		.amp_q(cos_amplitude_out)
	);

	property p_upd_pulse;
		@(posedge sys_clk) disable iff (srst)
		$rose(register_update_strobe_out) && !dir_in && !cmd_upd_q |-> register_update_strobe_out[*8];
	endproperty
	a_upd_pulse: assert property (p_upd_pulse) else $error("update pulse shorter than eight cycles");

	property p_upd_end;
		@(posedge sys_clk) disable iff (srst)
		!dir_in && cmd_upd_q ##1 !cmd_upd_q [*8] |=> !register_update_strobe_out;
	endproperty
	a_upd_end: assert property (p_upd_end) else $error("update pulse longer than eight cycles");

	property p_upd_dir;
		@(posedge sys_clk) disable iff (srst)
		$changed(dir_in) |=> register_update_strobe_oe == !$past(dir_in);
	endproperty
	a_upd_dir: assert property (p_upd_dir) else $error("update pin direction does not follow control");

	property p_upd_copy;
		@(posedge sys_clk) disable iff (srst)
		dir_in && upd_s && !upd_prev_q |=> act_q[synth_ctl_pkg::FREQ1_BYTE] == $past(buf_q[synth_ctl_pkg::FREQ1_BYTE]);
	endproperty
	a_upd_copy: assert property (p_upd_copy) else $error("update edge did not copy buffers");

	property p_fsk_sel;
		@(posedge sys_clk) disable iff (srst)
		mode == synth_ctl_pkg::MODE_FSK |=> freq_word_out == ($past(key_s) ? $past(f2) : $past(f1));
	endproperty
	a_fsk_sel: assert property (p_fsk_sel) else $error("frequency word does not follow keying pin");

	property p_bpsk_sel;
		@(posedge sys_clk) disable iff (srst)
		mode == synth_ctl_pkg::MODE_BPSK |=> phase_offset_out == ($past(key_s) ? $past(p2) : $past(p1));
	endproperty
	a_bpsk_sel: assert property (p_bpsk_sel) else $error("phase offset does not follow keying pin");

	property p_hold;
		@(posedge sys_clk) disable iff (srst)
		mode == synth_ctl_pkg::MODE_CHIRP && key_s |=> $stable(acc_q);
	endproperty
	a_hold: assert property (p_hold) else $error("accumulator moved during hold");

	property p_sweep;
		@(posedge sys_clk) disable iff (srst)
		mode == synth_ctl_pkg::MODE_CHIRP && !key_s |=> acc_q == 48'($past(acc_q) + $past(delta));
	endproperty
	a_sweep: assert property (p_sweep) else $error("accumulator did not advance");

	property p_par_read;
		@(posedge sys_clk) disable iff (srst)
		par_s && !rd_n_s |=> data_bus_oe && data_bus_out == $past(act_q[addr_s]);
	endproperty
	a_par_read: assert property (p_par_read) else $error("parallel read did not drive register data");

	property p_par_sdio;
		@(posedge sys_clk) disable iff (srst)
		par_s |=> !addr0_serial_data_io_oe;
	endproperty
	a_par_sdio: assert property (p_par_sdio) else $error("address pin driven in parallel mode");

	property p_single;
		@(posedge sys_clk) disable iff (srst)
		mode == synth_ctl_pkg::MODE_SINGLE |=> freq_word_out == $past(f1) && phase_offset_out == $past(p1);
	endproperty
	a_single: assert property (p_single) else $error("keying pin acted in single-tone mode");

	property p_osk_off;
		@(posedge sys_clk) disable iff (srst)
		!osk_en |=> cos_amplitude_out == synth_ctl_pkg::AMP_FULL;
	endproperty
	a_osk_off: assert property (p_osk_off) else $error("amplitude moved with shaped keying disabled");

	c_upd_pulse: cover property (@(posedge sys_clk) disable iff (srst) $rose(register_update_strobe_out));
	c_hold: cover property (@(posedge sys_clk) disable iff (srst) hold ##1 !hold);
	c_par_write: cover property (@(posedge sys_clk) disable iff (srst) par_s && wr_rise);
	c_ser_read: cover property (@(posedge sys_clk) disable iff (srst) $rose(addr0_serial_data_io_oe));
endmodule // synth_control_pin_interface

// >>> bench/synth_host_model.sv
`timescale 1ns/1ps
module synth_host_model (
	input wire logic sys_clk, // system clock
	output logic ser_par_select, // low serial, high parallel
	output logic [2:0] addr_upper_bits, // address bits 5..3
	output logic addr2_serial_port_reset, // address bit 2 or serial reset
	output logic addr1_in, // address bit 1
	output logic sdio_host, // host drive of address bit 0 or serial data
	output logic wr_sclk, // write strobe or serial clock
	output logic rd_cs_n, // read strobe or chip select
	output logic [7:0] data_bus_in, // parallel data
	output logic upd_host, // host drive of the update pin
	output logic keying_select_hold_pin, // keying select or hold
	output logic shaped_keying_pin, // shaped keying level
	input wire logic sdio_line // shared serial data line as seen at the pin
);
	initial begin
		{ser_par_select, rd_cs_n} = 2'b11;
		{addr_upper_bits, addr2_serial_port_reset, addr1_in, sdio_host, wr_sclk} = 7'h00;
		{data_bus_in, upd_host, keying_select_hold_pin, shaped_keying_pin} = 11'h000;
	end
	task automatic levels(input logic sp, input logic k, input logic o);
		ser_par_select <= sp;
		keying_select_hold_pin <= k;
		shaped_keying_pin <= o;
	endtask
	task automatic par_wr(input logic [5:0] a, input logic [7:0] d);
		{addr_upper_bits, addr2_serial_port_reset, addr1_in, sdio_host} <= a;
		data_bus_in <= d;
		repeat (4) @(posedge sys_clk);
		wr_sclk <= 1'b1;
		repeat (4) @(posedge sys_clk);
		wr_sclk <= 1'b0;
		// a released bus must not look like the byte just written
		data_bus_in <= ~d;
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic par_rd(input logic [5:0] a, input logic on);
		{addr_upper_bits, addr2_serial_port_reset, addr1_in, sdio_host} <= a;
		rd_cs_n <= !on;
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic ser_bits(input logic [15:0] v, input int n);
		for (int i = 15; i > 15 - n; i--) begin
			sdio_host = v[i];
			#62.5 wr_sclk = 1'b1;
			#62.5 wr_sclk = 1'b0;
		end
	endtask
	// junk bits then a port reset mimic a transfer that got stuck
	task automatic ser_wr(input logic [5:0] a, input logic [7:0] d, input int junk);
		#3 addr2_serial_port_reset = 1'b0;
		rd_cs_n = 1'b0;
		if (junk > 0) begin
			ser_bits(16'hffff, junk);
			addr2_serial_port_reset = 1'b1;
			#100 addr2_serial_port_reset = 1'b0;
			#100;
		end
		ser_bits({2'b00, a, d}, 16);
		#100 rd_cs_n = 1'b1;
		sdio_host = ~sdio_host;
		#200 @(posedge sys_clk);
	endtask
	task automatic ser_rd(input logic [5:0] a, output logic [7:0] d);
		#3 addr2_serial_port_reset = 1'b0;
		rd_cs_n = 1'b0;
		ser_bits({2'b10, a, 8'h00}, 8);
		// the device drives each bit from a fall; take it at the following rise
		for (int i = 7; i >= 0; i--) begin
			#62.5 wr_sclk = 1'b1;
			d[i] = sdio_line;
			#62.5 wr_sclk = 1'b0;
		end
		#100 rd_cs_n = 1'b1;
		#200 @(posedge sys_clk);
	endtask
	task automatic upd_pulse();
		upd_host <= 1'b1;
		repeat (4) @(posedge sys_clk);
		upd_host <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask
endmodule // synth_host_model

// >>> bench/synth_control_pin_interface_tb.sv
`timescale 1ns/1ps
module synth_control_pin_interface_tb;
	typedef struct packed {logic [1:0] kind; logic [47:0] val;} note_s;
	note_s exp_q[$];
	logic sys_clk, srst, hsel, hwrite, hreadyout, hresp, smp;
	logic [1:0] htrans;
	logic [2:0] hsize, psel, addr_upper_bits;
	logic [31:0] haddr, hwdata, hrdata;
	logic ser_par_select, addr2_serial_port_reset, addr1_in, addr0_serial_data_io_in;
	logic addr0_serial_data_io_out, addr0_serial_data_io_oe, wr_sclk, rd_cs_n, data_bus_oe;
	logic [7:0] data_bus_in, data_bus_out, nb, sb;
	logic register_update_strobe_in, register_update_strobe_out, register_update_strobe_oe;
	logic keying_select_hold_pin, shaped_keying_pin, sdio_host, upd_host, rd_dp = 1'b0;
	logic [47:0] freq_word_out, f1, f2;
	logic [13:0] phase_offset_out, p1, p2;
	logic [11:0] cos_amplitude_out;
	int n_errors = 0, num_checks = 0, cyc = 0, upd_len = 0;

	assign addr0_serial_data_io_in = addr0_serial_data_io_oe ? addr0_serial_data_io_out : sdio_host;
	assign register_update_strobe_in = register_update_strobe_oe ? register_update_strobe_out : upd_host;

	synth_control_pin_interface synth_control_pin_interface_i (
		.sys_clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .ser_par_select, .addr_upper_bits, .addr2_serial_port_reset, .addr1_in,
		.addr0_serial_data_io_in, .addr0_serial_data_io_out, .addr0_serial_data_io_oe, .wr_sclk, .rd_cs_n,
		.data_bus_in, .data_bus_out, .data_bus_oe, .register_update_strobe_in, .register_update_strobe_out,
		.register_update_strobe_oe, .keying_select_hold_pin, .shaped_keying_pin, .freq_word_out,
		.phase_offset_out, .cos_amplitude_out
	);
	synth_host_model synth_host_model_i (
		.sys_clk, .ser_par_select, .addr_upper_bits, .addr2_serial_port_reset, .addr1_in, .sdio_host,
		.wr_sclk, .rd_cs_n, .data_bus_in, .upd_host, .keying_select_hold_pin, .shaped_keying_pin,
		.sdio_line(addr0_serial_data_io_in)
	);

	always #5 sys_clk = ~sys_clk;

	task finish_test();
		if (exp_q.size() != 0) begin
			n_errors++;
			$display("MISMATCH %0t %0d expected results never appeared", $time, exp_q.size());
		end
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task note(input logic [1:0] k, input logic [47:0] v);
		exp_q.push_back('{k, v});
	endtask
	task cmp(input logic [1:0] k, input logic [47:0] v);
		note_s n;
		num_checks++;
		if (exp_q.size() == 0) begin
			n_errors++;
			$display("MISMATCH %0t unexpected result of kind %0d", $time, k);
		end else begin
			n = exp_q.pop_front();
			if (n.kind !== k || n.val !== v) begin
				n_errors++;
				$display("MISMATCH %0t kind %0d got %h expected %h", $time, k, v, n.val);
			end
		end
	endtask

	// results appear as read completions, sampled pins, or the end of an update pulse
	always @(posedge sys_clk) begin
		if (rd_dp && hreadyout === 1'b1)
			cmp(2'd0, {15'h0, hresp, hrdata});
		if (hsel && htrans[1] && hreadyout && !hwrite)
			rd_dp <= 1'b1;
		else if (hreadyout === 1'b1)
			rd_dp <= 1'b0;
		if (smp)
			case (psel)
				3'd0: cmp(2'd1, freq_word_out);
				3'd1: cmp(2'd1, {34'h0, phase_offset_out});
				3'd2: cmp(2'd1, {36'h0, cos_amplitude_out});
				3'd3: cmp(2'd1, {39'h0, data_bus_oe, data_bus_out});
				3'd4: cmp(2'd1, {40'h0, sb});
				default: cmp(2'd1, {47'h0, register_update_strobe_oe});
			endcase
		if (register_update_strobe_out === 1'b1)
			upd_len <= upd_len + 1;
		else if (upd_len != 0) begin
			cmp(2'd2, 48'(upd_len));
			upd_len <= 0;
		end
	end

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			$display("MISMATCH %0t run did not complete in time", $time);
			finish_test();
		end
	end

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h000000, a};
		do @(negedge sys_clk); while (hreadyout !== 1'b1);
		@(posedge sys_clk);
		htrans <= 2'b00;
		hwdata <= d;
		do @(negedge sys_clk); while (hreadyout !== 1'b1);
		@(posedge sys_clk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		note(2'd0, {16'h0000, e});
		bus(1'b0, a, 32'h0);
	endtask
	task pin_chk(input logic [2:0] s, input logic [47:0] e);
		note(2'd1, e);
		psel <= s;
		smp <= 1'b1;
		@(posedge sys_clk);
		smp <= 1'b0;
		@(posedge sys_clk);
	endtask
	task rd_byte(input logic [7:0] e);
		synth_host_model_i.par_rd(6'(synth_ctl_pkg::FREQ1_BYTE), 1'b1);
		pin_chk(3'd3, {39'h0, 1'b1, e});
		synth_host_model_i.par_rd(6'(synth_ctl_pkg::FREQ1_BYTE), 1'b0);
	endtask

	initial begin
		{sys_clk, srst, hsel, hwrite, smp} = 5'b01000;
		{htrans, psel, haddr, hwdata} = '0;
		hsize = 3'b010;
		void'($urandom(72967));
		f1 = {16'($urandom), $urandom};
		f2 = {16'($urandom), $urandom};
		p1 = 14'($urandom);
		p2 = 14'($urandom);
		nb = 8'($urandom);
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rd(synth_ctl_pkg::CTRL_OFFS, synth_ctl_pkg::CTRL_RESET);
		rd(8'h40, 32'h0);
		pin_chk(3'd5, 48'h1);
		pin_chk(3'd2, 48'hfff);
		for (int i = 0; i < 6; i++) begin
			synth_host_model_i.par_wr(6'(synth_ctl_pkg::FREQ1_BYTE + i), f1[47 - 8 * i -: 8]);
			synth_host_model_i.par_wr(6'(synth_ctl_pkg::FREQ2_BYTE + i), f2[47 - 8 * i -: 8]);
		end
		// buffers are not yet active, so the read still shows the reset byte
		rd_byte(8'h00);
		wr(synth_ctl_pkg::CTRL_OFFS, 32'h0000_0101);
		note(2'd2, 48'd8);
		wr(synth_ctl_pkg::CMD_OFFS, 32'h1);
		repeat (15) @(posedge sys_clk);
		rd_byte(f1[47:40]);
		for (int m = 1; m < 3; m++) begin
			wr(synth_ctl_pkg::CTRL_OFFS, 32'h0000_0100 + 32'(m));
			for (int k = 0; k < 2; k++) begin
				synth_host_model_i.levels(1'b1, k[0], 1'b0);
				repeat (4) @(posedge sys_clk);
				pin_chk(3'd0, k ? f2 : f1);
			end
		end
		wr(synth_ctl_pkg::CTRL_OFFS, 32'h0000_0100);
		repeat (4) @(posedge sys_clk);
		pin_chk(3'd0, f1);
		wr(synth_ctl_pkg::CTRL_OFFS, 32'h0000_0108);
		repeat (4) @(posedge sys_clk);
		pin_chk(3'd5, 48'h0);
		synth_host_model_i.par_wr(6'(synth_ctl_pkg::FREQ1_BYTE), nb);
		wr(synth_ctl_pkg::CMD_OFFS, 32'h1);
		repeat (15) @(posedge sys_clk);
		pin_chk(3'd0, f1);
		synth_host_model_i.upd_pulse();
		pin_chk(3'd0, {nb, f1[39:0]});
		f1[47:40] = nb;
		synth_host_model_i.levels(1'b0, 1'b0, 1'b0);
		wr(synth_ctl_pkg::CTRL_OFFS, 32'h0000_0104);
		synth_host_model_i.ser_wr(6'(synth_ctl_pkg::PHASE1_BYTE), {2'b00, p1[13:8]}, 5);
		synth_host_model_i.ser_wr(6'(synth_ctl_pkg::PHASE1_BYTE + 1), p1[7:0], 0);
		synth_host_model_i.ser_wr(6'(synth_ctl_pkg::PHASE2_BYTE), {2'b00, p2[13:8]}, 0);
		synth_host_model_i.ser_wr(6'(synth_ctl_pkg::PHASE2_BYTE + 1), p2[7:0], 0);
		synth_host_model_i.ser_wr(6'(synth_ctl_pkg::DELTA_BYTE + 5), 8'h01, 0);
		note(2'd2, 48'd8);
		wr(synth_ctl_pkg::CMD_OFFS, 32'h1);
		repeat (15) @(posedge sys_clk);
		for (int k = 0; k < 2; k++) begin
			synth_host_model_i.levels(1'b0, k[0], 1'b0);
			repeat (4) @(posedge sys_clk);
			pin_chk(3'd1, 48'(k ? p2 : p1));
		end
		pin_chk(3'd0, f1);
		synth_host_model_i.ser_rd(6'(synth_ctl_pkg::PHASE1_BYTE + 1), sb);
		pin_chk(3'd4, {40'h0, p1[7:0]});
		// hold is already engaged when chirp starts, so the accumulator sits at the first word
		wr(synth_ctl_pkg::CTRL_OFFS, 32'h0000_0103);
		repeat (6) @(posedge sys_clk);
		rd(synth_ctl_pkg::ACC_LO_OFFS, f1[31:0]);
		synth_host_model_i.levels(1'b0, 1'b0, 1'b0);
		repeat (20) @(posedge sys_clk);
		synth_host_model_i.levels(1'b0, 1'b1, 1'b0);
		repeat (6) @(posedge sys_clk);
		rd(synth_ctl_pkg::ACC_LO_OFFS, f1[31:0] + 32'd20);
		wr(synth_ctl_pkg::CTRL_OFFS, 32'h0000_0000);
		repeat (10) @(posedge sys_clk);
		pin_chk(3'd2, 48'hfff);
		wr(synth_ctl_pkg::CTRL_OFFS, 32'h0000_0010);
		repeat (4200) @(posedge sys_clk);
		pin_chk(3'd2, 48'h0);
		synth_host_model_i.levels(1'b0, 1'b1, 1'b1);
		repeat (4200) @(posedge sys_clk);
		pin_chk(3'd2, 48'hfff);
		finish_test();
	end
endmodule // synth_control_pin_interface_tb
